/* rtl/pcm_pin_mux.sv */
// Pin multiplexer for the last Port B pin and the first three Port C pins.
// Assumes pin inputs synchronous to MCLK; pads combine value and active-low enables.
`timescale 1ns/1ns
`include "pcm_defs.svh"
module pcm_pin_mux
  import pcm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [3:0] GPIO_DIR_IN,
  input wire logic [3:0] GPIO_OUT,
  input wire logic [7:0] GPIO_DRIVE,
  input wire logic [3:0] GPIO_IRQ_EN,
  input wire logic [1:0] PORT_C_FUNC,
  input wire logic SPI_IS_MASTER,
  input wire logic SPI_MASTER_IN_CH1_O,
  input wire logic SPI_MASTER_OUT_CH1_O,
  input wire logic SPI_SERIAL_CLOCK_CH1_O,
  input wire logic I2C_CLOCK_CH1_LOW,
  input wire logic I2C_DATA_CH1_LOW,
  input wire logic UART_TRANSMIT_CH1,
  input wire logic UART_RTS_ASSERT,
  input wire logic [3:0] PIN_I,
  output logic [3:0] PIN_O,
  output logic [3:0] PIN_OE_N,
  output logic [3:0] GPIO_IN,
  output logic [3:0] GPIO_IRQ,
  output logic SPI_MASTER_IN_CH1_I,
  output logic SPI_MASTER_OUT_CH1_I,
  output logic SPI_SERIAL_CLOCK_CH1_I,
  output logic I2C_CLOCK_CH1_I,
  output logic I2C_DATA_CH1_I,
  output logic UART_RECEIVE_CH1
);
  logic [3:0] g_o;
  logic [3:0] g_oe_n;
  logic [3:0] g_irq;
  logic [3:0] pin_o_nxt;
  logic [3:0] pin_oe_n_nxt;
  pcm_func_t func;

  assign func = pcm_func_t'(PORT_C_FUNC);

  genvar gi;
  generate
    for (gi = 0; gi < `PCM_NPINS; gi++)
    begin : g_pin
      pcm_gpio_pin u_pin (
        .clk(MCLK),
        .rst(RESET),
        .dir_in(GPIO_DIR_IN[gi]),
        .out_val(GPIO_OUT[gi]),
        .drive(GPIO_DRIVE[2*gi+1:2*gi]),
        .irq_en(GPIO_IRQ_EN[gi] && (gi == `PCM_PB7 || func == PCM_FN_GPIO)),
        .pin_i(PIN_I[gi]),
        .drv_o(g_o[gi]),
        .drv_oe_n(g_oe_n[gi]),
        .irq_o(g_irq[gi])
      );
    end
  endgenerate

  always_comb
  begin
    pin_o_nxt = g_o;
    pin_oe_n_nxt = g_oe_n;
    case (func)
      PCM_FN_SPI:
      begin
        pin_o_nxt[`PCM_PC0] = SPI_MASTER_IN_CH1_O;
        pin_oe_n_nxt[`PCM_PC0] = SPI_IS_MASTER;
        pin_o_nxt[`PCM_PC1] = SPI_MASTER_OUT_CH1_O;
        pin_oe_n_nxt[`PCM_PC1] = !SPI_IS_MASTER;
        pin_o_nxt[`PCM_PC2] = SPI_SERIAL_CLOCK_CH1_O;
        pin_oe_n_nxt[`PCM_PC2] = !SPI_IS_MASTER;
      end
      PCM_FN_I2C:
      begin
        pin_o_nxt[`PCM_PC0] = 1'b0;
        pin_oe_n_nxt[`PCM_PC0] = !I2C_CLOCK_CH1_LOW;
        pin_o_nxt[`PCM_PC1] = 1'b0;
        pin_oe_n_nxt[`PCM_PC1] = !I2C_DATA_CH1_LOW;
        pin_o_nxt[`PCM_PC2] = 1'b0;
        pin_oe_n_nxt[`PCM_PC2] = 1'b1;
      end
      PCM_FN_UART:
      begin
        pin_o_nxt[`PCM_PC0] = UART_TRANSMIT_CH1;
        pin_oe_n_nxt[`PCM_PC0] = 1'b0;
        pin_o_nxt[`PCM_PC1] = 1'b0;
        pin_oe_n_nxt[`PCM_PC1] = 1'b1;
        pin_o_nxt[`PCM_PC2] = !UART_RTS_ASSERT;
        pin_oe_n_nxt[`PCM_PC2] = 1'b0;
      end
      default:
      begin
        pin_o_nxt = g_o;
        pin_oe_n_nxt = g_oe_n;
      end
    endcase
  end

  // one driver per pin at a time.
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      PIN_O <= 4'h0;
      PIN_OE_N <= 4'hf;
    end
    else
    begin
      PIN_O <= pin_o_nxt;
      PIN_OE_N <= pin_oe_n_nxt;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
      GPIO_IRQ <= 4'h0;
    else
      GPIO_IRQ <= g_irq;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      GPIO_IN <= 4'h0;
      SPI_MASTER_IN_CH1_I <= 1'b0;
      SPI_MASTER_OUT_CH1_I <= 1'b0;
      SPI_SERIAL_CLOCK_CH1_I <= 1'b0;
      I2C_CLOCK_CH1_I <= 1'b1;
      I2C_DATA_CH1_I <= 1'b1;
      UART_RECEIVE_CH1 <= 1'b1;
    end
    else
    begin
      GPIO_IN <= PIN_I;
      SPI_MASTER_IN_CH1_I <= PIN_I[`PCM_PC0];
      SPI_MASTER_OUT_CH1_I <= PIN_I[`PCM_PC1];
      SPI_SERIAL_CLOCK_CH1_I <= PIN_I[`PCM_PC2];
      I2C_CLOCK_CH1_I <= PIN_I[`PCM_PC0];
      I2C_DATA_CH1_I <= PIN_I[`PCM_PC1];
      UART_RECEIVE_CH1 <= PIN_I[`PCM_PC1];
    end
  end

  open_drain_a: assert property (@(posedge MCLK) disable iff (RESET)
    (GPIO_DIR_IN[0] == 1'b0 && GPIO_DRIVE[1:0] == 2'h1)
    |=> (PIN_OE_N[0] || !PIN_O[0]))
    else $error("open-drain pin drove high");
  open_source_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func == PCM_FN_GPIO && GPIO_DIR_IN[3] == 1'b0 && GPIO_DRIVE[7:6] == 2'h2)
    |=> (PIN_OE_N[3] || PIN_O[3]))
    else $error("open-source pin drove low");
  miso_dir_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func == PCM_FN_SPI && SPI_IS_MASTER) |=> PIN_OE_N[1])
    else $error("master-in driven while master");
  mosi_dir_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func == PCM_FN_SPI && SPI_IS_MASTER) |=> !PIN_OE_N[2])
    else $error("master-out not driven while master");
  spi_slave_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func == PCM_FN_SPI && !SPI_IS_MASTER) |=> (!PIN_OE_N[1] && PIN_OE_N[2] && PIN_OE_N[3]))
    else $error("SPI slave directions wrong");
  rts_level_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func == PCM_FN_UART) |=> (PIN_O[3] == !$past(UART_RTS_ASSERT) && !PIN_OE_N[3]))
    else $error("request-to-send level wrong");
  uart_tx_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func == PCM_FN_UART) |=> (PIN_O[1] == $past(UART_TRANSMIT_CH1) && PIN_OE_N[2]))
    else $error("UART pins wrong");
  i2c_clock_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func == PCM_FN_I2C && I2C_CLOCK_CH1_LOW) |=> (!PIN_OE_N[1] && !PIN_O[1])
    ##1 (I2C_CLOCK_CH1_I == $past(PIN_I[1])))
    else $error("I2C clock wrong");
  pb_irq_a: assert property (@(posedge MCLK) disable iff (RESET)
    (GPIO_IRQ_EN[0] && GPIO_DIR_IN[0] && !$past(RESET) && $changed(PIN_I[0])) |=> GPIO_IRQ[0])
    else $error("interrupt request missed");
  pc_irq_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func == PCM_FN_GPIO && GPIO_IRQ_EN[3] && GPIO_DIR_IN[3] && !$past(RESET)
    && $changed(PIN_I[3])) |=> GPIO_IRQ[3])
    else $error("Port C interrupt request missed");
  irq_serial_a: assert property (@(posedge MCLK) disable iff (RESET)
    (func != PCM_FN_GPIO) |=> (GPIO_IRQ[3:1] == 3'h0))
    else $error("interrupt request in serial function");
  gpio_dir_a: assert property (@(posedge MCLK) disable iff (RESET)
    GPIO_DIR_IN[0] |=> PIN_OE_N[0])
    else $error("input pin driven");

  spi_cov_c: cover property (@(posedge MCLK) func == PCM_FN_SPI && !SPI_IS_MASTER);
  i2c_cov_c: cover property (@(posedge MCLK) func == PCM_FN_I2C && I2C_DATA_CH1_LOW);
  uart_cov_c: cover property (@(posedge MCLK) func == PCM_FN_UART && UART_RTS_ASSERT);
  irq_cov_c: cover property (@(posedge MCLK) GPIO_IRQ[3]);
endmodule

/* pkg/pcm_defs.svh */
// Constants for the Port C low pin multiplexer: pin count, pin indices, reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PCM_DEFS_SVH
`define PCM_DEFS_SVH
`define PCM_NPINS 4
`define PCM_PB7 0
`define PCM_PC0 1
`define PCM_PC1 2
`define PCM_PC2 3
`define PCM_DIR_RST 4'hf
`define PCM_OUT_RST 4'h0
`define PCM_DRV_RST 2'h0
`define PCM_IRQ_RST 4'h0
`define PCM_FUNC_RST 2'h0
`endif

/* pkg/pcm_pkg.sv */
// Types for the Port C low pin multiplexer.
// Assumes pcm_defs.svh is on the include path.
`include "pcm_defs.svh"
package pcm_pkg;
  // Function selected for the Port C pins.
  typedef enum logic [1:0] {
    PCM_FN_GPIO = 2'h0,
    PCM_FN_SPI = 2'h1,
    PCM_FN_I2C = 2'h2,
    PCM_FN_UART = 2'h3
  } pcm_func_t;
  // Output drive style of a GPIO pin.
  typedef enum logic [1:0] {
    PCM_DRV_PUSH = 2'h0,
    PCM_DRV_OPEN_DRAIN = 2'h1,
    PCM_DRV_OPEN_SOURCE = 2'h2
  } pcm_drive_t;
endpackage

/* rtl/pcm_gpio_pin.sv */
// One general-purpose pin: direction, drive style and level-change interrupt request.
// Assumes the pin input is synchronous to the clock.
`timescale 1ns/1ns
module pcm_gpio_pin
  import pcm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic dir_in,
  input wire logic out_val,
  input wire logic [1:0] drive,
  input wire logic irq_en,
  input wire logic pin_i,
  output logic drv_o,
  output logic drv_oe_n,
  output logic irq_o
);
  logic prev_r;

  always_comb
  begin
    drv_o = out_val;
    drv_oe_n = 1'b1;
    if (!dir_in)
    begin
      case (drive)
        2'h1: drv_oe_n = out_val;
        2'h2: drv_oe_n = !out_val;
        default: drv_oe_n = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prev_r <= 1'b0;
    else
      prev_r <= pin_i;
  end

  assign irq_o = irq_en && dir_in && (prev_r != pin_i);
endmodule

/* bench/pcm_ext_model.sv */
// Parts wired to the four pads.
// Assumes active-low pad enables from the multiplexer.
`timescale 1ns/1ns
module pcm_ext_model
(
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] ext_val,
  input wire logic [3:0] ext_en,
  output logic [3:0] pin_i
);
  // A pad that nobody drives shows the inverse of the multiplexer's output value for it.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!pin_oe_n[i])
        pin_i[i] = pin_o[i];
      else if (ext_en[i])
        pin_i[i] = ext_val[i];
      else
        pin_i[i] = ~pin_o[i];
    end
  end
endmodule

/* bench/port_c_low_pin_mux_test.sv */
// Self-checking bench for the pin multiplexer.
// Assumes pcm_pin_mux and the pad model are compiled first.
`timescale 1ns/1ns
module port_c_low_pin_mux_test;
  import pcm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] dir = 4'hf, out = 4'h0, ien = 4'h0, ev = 4'h0, ee = 4'h0;
  logic [7:0] drv = 8'h00;
  logic [1:0] fn = 2'h0;
  logic mst = 1'b1, smi = 1'b0, smo = 1'b0, sck = 1'b0, scl = 1'b0, sda = 1'b0;
  logic tx = 1'b0, rts = 1'b0;
  logic [3:0] pin_i, po, poe, gin, irq;
  logic mi, mo, ck, ci, di, rx;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  pcm_pin_mux dut_u (.MCLK(clk), .RESET(rst), .GPIO_DIR_IN(dir), .GPIO_OUT(out),
    .GPIO_DRIVE(drv), .GPIO_IRQ_EN(ien), .PORT_C_FUNC(fn), .SPI_IS_MASTER(mst),
    .SPI_MASTER_IN_CH1_O(smi), .SPI_MASTER_OUT_CH1_O(smo),
    .SPI_SERIAL_CLOCK_CH1_O(sck), .I2C_CLOCK_CH1_LOW(scl), .I2C_DATA_CH1_LOW(sda),
    .UART_TRANSMIT_CH1(tx), .UART_RTS_ASSERT(rts), .PIN_I(pin_i), .PIN_O(po),
    .PIN_OE_N(poe), .GPIO_IN(gin), .GPIO_IRQ(irq), .SPI_MASTER_IN_CH1_I(mi),
    .SPI_MASTER_OUT_CH1_I(mo), .SPI_SERIAL_CLOCK_CH1_I(ck), .I2C_CLOCK_CH1_I(ci),
    .I2C_DATA_CH1_I(di), .UART_RECEIVE_CH1(rx));
  pcm_ext_model ext_u (.pin_o(po), .pin_oe_n(poe), .ext_val(ev), .ext_en(ee),
    .pin_i(pin_i));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic t_gpio;
    dir = 4'ha;
    out = 4'h5;
    ee = 4'ha;
    ev = 4'h8;
    step(2);
    chk("dir", 4'ha, poe);
    chk("out", 4'h3, {po[2], po[0]});
    chk("in", 4'h2, {gin[3], gin[1]});
  endtask
  task automatic t_drive;
    dir = 4'h0;
    out = 4'h3;
    drv = 8'h99;
    step(2);
    chk("drive oe", 4'h9, poe);
    chk("drive val", 4'h1, {po[2], po[1]});
    drv = 8'h00;
  endtask
  task automatic t_irq;
    dir = 4'h1;
    ee = 4'h1;
    ev = 4'h0;
    ien = 4'h1;
    step(3);
    chk("irq idle", 4'h0, irq);
    ev = 4'h1;
    step(1);
    chk("irq set", 4'h1, irq);
    step(1);
    chk("irq pulse", 4'h0, irq);
    ien = 4'h0;
    ev = 4'h0;
    step(2);
    chk("irq off", 4'h0, irq);
  endtask
  task automatic t_spi;
    fn = 2'h1;
    dir = 4'hf;
    smo = 1'b1;
    sck = 1'b1;
    ee = 4'h2;
    ev = 4'h2;
    step(2);
    chk("spi m oe", 4'h3, poe);
    chk("spi m out", 4'h3, po[3:2]);
    chk("spi m in", 4'h1, mi);
    mst = 1'b0;
    smi = 1'b1;
    ee = 4'hc;
    ev = 4'h8;
    step(2);
    chk("spi s oe", 4'hd, poe);
    chk("spi s out", 4'h1, po[1]);
    chk("spi s in", 4'h2, {ck, mo});
  endtask
  task automatic t_i2c;
    fn = 2'h2;
    scl = 1'b1;
    sda = 1'b1;
    ee = 4'h4;
    ev = 4'h0;
    step(2);
    chk("i2c oe", 4'h9, poe);
    chk("i2c low", 4'h0, {po[2], po[1], ci, di});
    scl = 1'b0;
    sda = 1'b0;
    ee = 4'h2;
    step(2);
    chk("i2c rel", 4'h2, {poe[1], ci});
    chk("i2c data rel", 4'h1, poe[2]);
    ev = 4'h2;
    step(2);
    chk("i2c sense", 4'h1, ci);
  endtask
  task automatic t_uart;
    fn = 2'h3;
    rts = 1'b1;
    tx = 1'b1;
    ee = 4'h4;
    ev = 4'h4;
    step(2);
    chk("uart oe", 4'h5, poe);
    chk("uart on", 4'h3, {po[3], po[1], rx});
    rts = 1'b0;
    tx = 1'b0;
    ev = 4'h0;
    step(2);
    chk("uart off", 4'h4, {po[3], po[1], rx});
  endtask
  task automatic t_pc_irq;
    fn = 2'h0;
    dir = 4'h8;
    ee = 4'h8;
    ev = 4'h0;
    ien = 4'h8;
    step(3);
    chk("pc irq idle", 4'h0, irq);
    ev = 4'h8;
    step(1);
    chk("pc irq set", 4'h8, irq);
    ev = 4'h0;
    fn = 2'h1;
    step(1);
    chk("pc irq refused", 4'h0, irq);
    ien = 4'h0;
    fn = 2'h0;
    step(2);
  endtask
  initial
  begin
    step(12);
    chk("rst pad", 4'h0, po);
    chk("rst oe", 4'hf, poe);
    chk("rst ins", 4'h7, {ci, di, rx});
    rst = 1'b0;
    t_gpio();
    t_drive();
    t_irq();
    t_spi();
    t_i2c();
    t_uart();
    t_pc_irq();
    give_verdict();
  end
endmodule
